/* hdl/awd_top.v */
// ADC window detector: register port, conversion control, result formatting and window compare.
// Assumes the analog core presents a 10-bit code that is valid when the sequencer ends a conversion,
// and a one-cycle external start pulse for the non-software start modes.
`timescale 1ns/1ps
`default_nettype none
`include "awd_consts.vh"

module awd_top #(
  parameter CODE_W = 10
) (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire [7:0] sfr_addr_in,
  input wire [7:0] sfr_wdata_in,
  input wire sfr_wr_in,
  input wire sfr_rd_in,
  output reg [7:0] sfr_rdata_out,
  input wire diff_mode_in,
  input wire start_trigger_in,
  input wire [CODE_W-1:0] analog_code_in,
  output reg adc_enable_out,
  output reg conversion_done_flag_out,
  output reg window_match_flag_out,
  output wire busy_out
);

  localparam [5:0] LJ_PAD = 6'h00;
  localparam [7:0] RST_CFG = `AWD_RST_CONFIG;

  // Register file
  reg [7:0] window_low_limit_lsb_ff;
  reg [7:0] window_low_limit_msb_ff;
  reg [7:0] window_high_limit_lsb_ff;
  reg [7:0] window_high_limit_msb_ff;
  reg [4:0] sar_div_ff;
  reg left_justify_select_ff;
  reg enable_ff;
  reg track_mode_ff;
  reg [2:0] start_mode_ff;
  reg conversion_done_flag_ff;
  reg window_match_flag_ff;
  reg [7:0] result_msb_ff;
  reg [7:0] result_lsb_ff;

  reg [7:0] nxt_rdata;
  reg nxt_done_flag;
  reg nxt_match_flag;

  wire wr_control = sfr_wr_in && (sfr_addr_in == `AWD_ADDR_CONTROL);
  wire conv_done;

  // Conversion start
  wire sw_start = wr_control && sfr_wdata_in[`AWD_CTL_BUSY] && (start_mode_ff == `AWD_MODE_SOFTWARE);
  wire hw_start = start_trigger_in && (start_mode_ff != `AWD_MODE_SOFTWARE);
  wire conv_start = enable_ff && (sw_start || hw_start);

  awd_sar_seq #(
    .DIV_W(5),
    .PERIODS(`AWD_CONV_PERIODS)
  ) u_seq (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .start_in(conv_start),
    .div_in(sar_div_ff),
    .busy_out(busy_out),
    .done_out(conv_done)
  );

  // Result formatting
  wire [15:0] code_right = {{6{analog_code_in[CODE_W-1]}}, analog_code_in};
  wire [15:0] code_left = {analog_code_in, LJ_PAD};
  wire [15:0] result_word = left_justify_select_ff ? code_left : code_right;

  // Comparison word: single-ended right-justified codes are zero-extended, since
  // the sign-extended register image would make codes above 511 look huge.
  wire [15:0] cmp_se = left_justify_select_ff ? code_left : {6'h00, analog_code_in};
  wire [15:0] cmp_word = diff_mode_in ? result_word : cmp_se;

  wire [15:0] low_limit = {window_low_limit_msb_ff, window_low_limit_lsb_ff};
  wire [15:0] high_limit = {window_high_limit_msb_ff, window_high_limit_lsb_ff};

  // Extra top bit turns every compare into a signed 17-bit compare
  wire ext_res = diff_mode_in & cmp_word[15];
  wire ext_lo = diff_mode_in & low_limit[15];
  wire ext_hi = diff_mode_in & high_limit[15];
  wire signed [16:0] s_res = {ext_res, cmp_word};
  wire signed [16:0] s_lo = {ext_lo, low_limit};
  wire signed [16:0] s_hi = {ext_hi, high_limit};

  wire res_above_hi = (s_res > s_hi);
  wire res_below_lo = (s_res < s_lo);
  wire lo_above_hi = (s_lo > s_hi);

  // Equal limits fall in the outside form: every result except the limit matches
  wire inside_hit = lo_above_hi && res_above_hi && res_below_lo;
  wire outside_hit = !lo_above_hi && (res_below_lo || res_above_hi);
  wire window_hit = inside_hit || outside_hit;

  // Flag next state: a hardware set in the same cycle as a software clear wins
  always @*
  begin
    nxt_done_flag = conversion_done_flag_ff;
    nxt_match_flag = window_match_flag_ff;
    if (wr_control)
    begin
      nxt_done_flag = sfr_wdata_in[`AWD_CTL_DONE];
      nxt_match_flag = sfr_wdata_in[`AWD_CTL_WMATCH];
    end
    if (conv_done)
    begin
      nxt_done_flag = 1'b1;
      if (window_hit)
      begin
        nxt_match_flag = 1'b1;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @*
  begin
    nxt_rdata = 8'h00;
    case (sfr_addr_in)
      `AWD_ADDR_CONFIG:
      begin
        nxt_rdata = {sar_div_ff, left_justify_select_ff, 2'b00};
      end
      `AWD_ADDR_RESULT_LSB:
      begin
        nxt_rdata = result_lsb_ff;
      end
      `AWD_ADDR_RESULT_MSB:
      begin
        nxt_rdata = result_msb_ff;
      end
      `AWD_ADDR_HIGH_LSB:
      begin
        nxt_rdata = window_high_limit_lsb_ff;
      end
      `AWD_ADDR_HIGH_MSB:
      begin
        nxt_rdata = window_high_limit_msb_ff;
      end
      `AWD_ADDR_LOW_LSB:
      begin
        nxt_rdata = window_low_limit_lsb_ff;
      end
      `AWD_ADDR_LOW_MSB:
      begin
        nxt_rdata = window_low_limit_msb_ff;
      end
      `AWD_ADDR_CONTROL:
      begin
        nxt_rdata = {enable_ff, track_mode_ff, conversion_done_flag_ff, busy_out,
                     window_match_flag_ff, start_mode_ff};
      end
      default:
      begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  // Register writes
  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      window_low_limit_lsb_ff <= `AWD_RST_LIMIT;
      window_low_limit_msb_ff <= `AWD_RST_LIMIT;
      window_high_limit_lsb_ff <= `AWD_RST_HIGH_LIMIT;
      window_high_limit_msb_ff <= `AWD_RST_HIGH_LIMIT;
      sar_div_ff <= RST_CFG[`AWD_CFG_DIV_MSB:`AWD_CFG_DIV_LSB];
      left_justify_select_ff <= RST_CFG[`AWD_CFG_LJUST];
    end
    else if (sfr_wr_in)
    begin
      case (sfr_addr_in)
        `AWD_ADDR_LOW_LSB:
        begin
          window_low_limit_lsb_ff <= sfr_wdata_in;
        end
        `AWD_ADDR_LOW_MSB:
        begin
          window_low_limit_msb_ff <= sfr_wdata_in;
        end
        `AWD_ADDR_HIGH_LSB:
        begin
          window_high_limit_lsb_ff <= sfr_wdata_in;
        end
        `AWD_ADDR_HIGH_MSB:
        begin
          window_high_limit_msb_ff <= sfr_wdata_in;
        end
        `AWD_ADDR_CONFIG:
        begin
          sar_div_ff <= sfr_wdata_in[`AWD_CFG_DIV_MSB:`AWD_CFG_DIV_LSB];
          left_justify_select_ff <= sfr_wdata_in[`AWD_CFG_LJUST];
        end
        default:
        begin
          sar_div_ff <= sar_div_ff;
        end
      endcase
    end
  end

  // Control register, flags and result capture
  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      enable_ff <= 1'b0;
      track_mode_ff <= 1'b0;
      start_mode_ff <= `AWD_MODE_SOFTWARE;
      conversion_done_flag_ff <= 1'b0;
      window_match_flag_ff <= 1'b0;
      result_msb_ff <= `AWD_RST_RESULT;
      result_lsb_ff <= `AWD_RST_RESULT;
    end
    else
    begin
      conversion_done_flag_ff <= nxt_done_flag;
      window_match_flag_ff <= nxt_match_flag;
      if (wr_control)
      begin
        enable_ff <= sfr_wdata_in[`AWD_CTL_ENABLE];
        track_mode_ff <= sfr_wdata_in[`AWD_CTL_TRACK];
        start_mode_ff <= sfr_wdata_in[`AWD_CTL_MODE_MSB:`AWD_CTL_MODE_LSB];
      end
      if (conv_done)
      begin
        result_msb_ff <= result_word[15:8];
        result_lsb_ff <= result_word[7:0];
      end
    end
  end

  // Registered outputs; flag outputs mirror the next state so they line up with the flags
  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sfr_rdata_out <= 8'h00;
      adc_enable_out <= 1'b0;
      conversion_done_flag_out <= 1'b0;
      window_match_flag_out <= 1'b0;
    end
    else
    begin
      if (sfr_rd_in)
      begin
        sfr_rdata_out <= nxt_rdata;
      end
      adc_enable_out <= wr_control ? sfr_wdata_in[`AWD_CTL_ENABLE] : enable_ff;
      conversion_done_flag_out <= nxt_done_flag;
      window_match_flag_out <= nxt_match_flag;
    end
  end

endmodule // awd_top

`default_nettype wire

/* include/awd_consts.vh */
// Constants for the ADC window detector: register addresses, field positions, reset values, counts.
// Assumes an 8-bit register port with byte-wide addresses and a 10-bit conversion code.
`ifndef AWD_CONSTS_VH
`define AWD_CONSTS_VH

`define AWD_ADDR_CONFIG 8'hbc
`define AWD_ADDR_RESULT_LSB 8'hbd
`define AWD_ADDR_RESULT_MSB 8'hbe
`define AWD_ADDR_HIGH_LSB 8'hc3
`define AWD_ADDR_HIGH_MSB 8'hc4
`define AWD_ADDR_LOW_LSB 8'hc5
`define AWD_ADDR_LOW_MSB 8'hc6
`define AWD_ADDR_CONTROL 8'he8

`define AWD_RST_CONFIG 8'hf8
`define AWD_RST_CONTROL 8'h00
`define AWD_RST_LIMIT 8'h00
`define AWD_RST_RESULT 8'h00
`define AWD_RST_HIGH_LIMIT 8'hff

`define AWD_CFG_DIV_MSB 7
`define AWD_CFG_DIV_LSB 3
`define AWD_CFG_LJUST 2

`define AWD_CTL_ENABLE 7
`define AWD_CTL_TRACK 6
`define AWD_CTL_DONE 5
`define AWD_CTL_BUSY 4
`define AWD_CTL_WMATCH 3
`define AWD_CTL_MODE_MSB 2
`define AWD_CTL_MODE_LSB 0
`define AWD_MODE_SOFTWARE 3'h0

`define AWD_CONV_PERIODS 10

`endif

/* hdl/awd_sar_seq.v */
// SAR conversion sequencer: divides the system clock to the SAR clock and times one conversion.
// Assumes start is a one-cycle pulse; the analog core holds its code stable while busy is high.
`timescale 1ns/1ps
`default_nettype none
`include "awd_consts.vh"

module awd_sar_seq #(
  parameter DIV_W = 5,
  parameter PERIODS = `AWD_CONV_PERIODS
) (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire start_in,
  input wire [DIV_W-1:0] div_in,
  output reg busy_out,
  output reg done_out
);

  localparam [31:0] PERIOD_LAST_W = PERIODS - 1;
  localparam [3:0] PERIOD_LAST = PERIOD_LAST_W[3:0];

  reg [DIV_W-1:0] div_cnt_ff;
  reg [3:0] per_cnt_ff;
  reg [DIV_W-1:0] div_latch_ff;

  wire sar_tick = (div_cnt_ff == div_latch_ff);

  // Done is a strobe in the cycle of the final tick, so flags and result land on the edge
  // that drops busy, while the analog code is still guaranteed valid
  always @*
  begin
    done_out = busy_out && sar_tick && (per_cnt_ff == PERIOD_LAST);
  end

  // Divider value is latched at start so a config write mid-conversion cannot stretch it
  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      busy_out <= 1'b0;
      div_cnt_ff <= {DIV_W{1'b0}};
      per_cnt_ff <= 4'h0;
      div_latch_ff <= {DIV_W{1'b0}};
    end
    else
    begin
      if (!busy_out)
      begin
        if (start_in)
        begin
          busy_out <= 1'b1;
          div_cnt_ff <= {DIV_W{1'b0}};
          per_cnt_ff <= 4'h0;
          div_latch_ff <= div_in;
        end
      end
      else if (sar_tick)
      begin
        div_cnt_ff <= {DIV_W{1'b0}};
        if (per_cnt_ff == PERIOD_LAST)
        begin
          busy_out <= 1'b0;
        end
        else
        begin
          per_cnt_ff <= per_cnt_ff + 4'h1;
        end
      end
      else
      begin
        div_cnt_ff <= div_cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // awd_sar_seq

`default_nettype wire

/* tb/awd_checker.sv */
// Checker for awd_top: register port, conversion timing and window flag.
// Assumes it is bound to awd_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module awd_checker (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic start_trigger_in,
  input wire logic adc_enable_out,
  input wire logic conversion_done_flag_out,
  input wire logic window_match_flag_out,
  input wire logic busy_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic ctl_wr;
  logic [2:0] mode_ff;
  logic [4:0] div_ff;
  logic [4:0] div_lat_ff;
  logic [7:0] low_lsb_ff;
  logic [9:0] busy_cnt_ff;
  assign ctl_wr = sfr_wr_in && sfr_addr_in == 8'he8;
  // Shadows of stored fields; divider is frozen while busy as the design latches it at start
  always_ff @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      mode_ff <= 3'h0;
      div_ff <= 5'h1f;
      div_lat_ff <= 5'h1f;
      low_lsb_ff <= 8'h00;
      busy_cnt_ff <= 10'h000;
    end
    else
    begin
      if (ctl_wr)
        mode_ff <= sfr_wdata_in[2:0];
      if (sfr_wr_in && sfr_addr_in == 8'hbc)
        div_ff <= sfr_wdata_in[7:3];
      if (sfr_wr_in && sfr_addr_in == 8'hc5)
        low_lsb_ff <= sfr_wdata_in;
      if (!busy_out)
        div_lat_ff <= div_ff;
      busy_cnt_ff <= busy_out ? busy_cnt_ff + 10'h001 : 10'h000;
    end
  soft_start_a: assert property (ctl_wr && sfr_wdata_in[4] && adc_enable_out && mode_ff == 3'h0 && !busy_out
    |=> busy_out) else $error("start did not raise busy");
  idle_stays_a: assert property (!busy_out && !ctl_wr && !start_trigger_in |=> !busy_out)
    else $error("busy without a start");
  conv_length_a: assert property ($fell(busy_out) |-> busy_cnt_ff == 10 * (div_lat_ff + 1))
    else $error("wrong conversion length");
  done_at_end_a: assert property ($fell(busy_out) |-> conversion_done_flag_out)
    else $error("done flag missing at end");
  match_at_end_a: assert property ($rose(window_match_flag_out) && !$past(ctl_wr) |-> $fell(busy_out))
    else $error("match flag set off conversion end");
  match_sticky_a: assert property (window_match_flag_out && !ctl_wr |=> window_match_flag_out)
    else $error("match flag dropped");
  match_clear_a: assert property (ctl_wr && !sfr_wdata_in[3] && !busy_out |=> !window_match_flag_out)
    else $error("match flag not cleared");
  rdata_hold_a: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
    else $error("read data moved");
  low_lsb_read_a: assert property (sfr_rd_in && sfr_addr_in == 8'hc5 |=> sfr_rdata_out == $past(low_lsb_ff))
    else $error("low limit lsb read wrong");
endmodule // awd_checker
bind awd_top awd_checker chk_u (.core_clk_in, .reset_n_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in,
  .sfr_rdata_out, .start_trigger_in, .adc_enable_out, .conversion_done_flag_out, .window_match_flag_out, .busy_out);
`default_nettype wire

/* tb/awd_core_model.sv */
// Analog core stand-in: presents the conversion code to the detector.
// Assumes the code is sampled only while busy is high.
`timescale 1ns/1ps
`default_nettype none
module awd_core_model (
  input wire logic busy_in,
  input wire logic [9:0] code_in,
  output logic [9:0] analog_code_out
);
  // Outside a conversion show the inverse, so a mistimed sample cannot pass
  assign analog_code_out = busy_in ? code_in : ~code_in;
endmodule // awd_core_model
`default_nettype wire

/* tb/adc_window_detector_tb.sv */
// Testbench for awd_top: registers, window compare in single-ended, differential and single-ended left-justified modes, timing.
// Assumes awd_checker is bound and awd_core_model supplies the code.
`timescale 1ns/1ps
`default_nettype none
module adc_window_detector_tb;
  logic clk, rst_n, wr, rd, diff, trig, lj, en, done, wm, busy;
  logic [7:0] addr, wdata, rdata, ctl_v;
  logic [9:0] code, acode;
  int err_total, n_checks;
  awd_top dut_u (.core_clk_in(clk), .reset_n_in(rst_n), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata), .diff_mode_in(diff), .start_trigger_in(trig),
    .analog_code_in(acode), .adc_enable_out(en), .conversion_done_flag_out(done),
    .window_match_flag_out(wm), .busy_out(busy));
  awd_core_model core_u (.busy_in(busy), .code_in(code), .analog_code_out(acode));
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    rd = 1;
    addr = a;
    @(negedge clk);
    rd = 0;
    chk(rdata, e);
  endtask
  task automatic lim(input logic [15:0] lo, input logic [15:0] hi);
    wr_reg(8'hc5, lo[7:0]);
    wr_reg(8'hc6, lo[15:8]);
    wr_reg(8'hc3, hi[7:0]);
    wr_reg(8'hc4, hi[15:8]);
  endtask
  task automatic conv(input logic [9:0] c, input logic m, input int len);
    logic [15:0] img;
    int n;
    img = lj ? {c, 6'h00} : {{6{c[9]}}, c};
    code = c;
    wr_reg(8'he8, ctl_v);
    if (ctl_v[2:0] != 3'h0)
    begin
      @(negedge clk);
      trig = 1;
      @(negedge clk);
      trig = 0;
    end
    n = 0;
    while (busy === 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk(n[7:0], len[7:0]);
    chk({7'h0, done}, 8'h01);
    chk({7'h0, wm}, {7'h0, m});
    rd_reg(8'hbd, img[7:0]);
    rd_reg(8'hbe, img[15:8]);
  endtask
  task automatic t_regs();
    rd_reg(8'hbc, 8'hf8);
    rd_reg(8'hc5, 8'h00);
    rd_reg(8'hc3, 8'hff);
    rd_reg(8'h00, 8'h00);
    wr_reg(8'hc5, 8'ha5);
    wr_reg(8'hc6, 8'h5a);
    wr_reg(8'hbd, 8'h33);
    rd_reg(8'hc5, 8'ha5);
    rd_reg(8'hc6, 8'h5a);
    rd_reg(8'hbd, 8'h00);
    wr_reg(8'hbc, 8'h00);
    wr_reg(8'he8, 8'h80);
  endtask
  task automatic t_single();
    lim(16'h0080, 16'h0040);
    conv(10'h040, 0, 10);
    conv(10'h041, 1, 10);
    conv(10'h07f, 1, 10);
    conv(10'h080, 0, 10);
    lim(16'h0300, 16'h0000);
    conv(10'h200, 1, 10);
    lim(16'h0040, 16'h0080);
    conv(10'h03f, 1, 10);
    conv(10'h040, 0, 10);
    conv(10'h080, 0, 10);
    conv(10'h081, 1, 10);
  endtask
  task automatic t_diff();
    diff = 1;
    lim(16'h0040, 16'hffff);
    conv(10'h3ff, 0, 10);
    conv(10'h000, 1, 10);
    conv(10'h03f, 1, 10);
    conv(10'h200, 0, 10);
    lim(16'hffff, 16'h0040);
    conv(10'h3fe, 1, 10);
    conv(10'h3ff, 0, 10);
    conv(10'h041, 1, 10);
    diff = 0;
  endtask
  task automatic t_left();
    lj = 1;
    wr_reg(8'hbc, 8'h04);
    lim(16'h2000, 16'h1000);
    conv(10'h041, 1, 10);
    conv(10'h040, 0, 10);
    lj = 0;
  endtask
  task automatic t_misc();
    wr_reg(8'hbc, 8'h08);
    lim(16'h0080, 16'h0040);
    ctl_v = 8'h81;
    conv(10'h041, 1, 20);
    ctl_v = 8'h90;
    // Software start is judged against the stored mode, so put it back to 000 first
    wr_reg(8'he8, 8'h80);
    conv(10'h040, 0, 20);
    wr_reg(8'he8, 8'h98);
    repeat (25) @(negedge clk);
    chk({7'h0, wm}, 8'h01);
    // Enable must already be clear for the start request to be dropped
    wr_reg(8'he8, 8'h00);
    wr_reg(8'he8, 8'h10);
    repeat (2) @(negedge clk);
    chk({6'h0, en, busy}, 8'h00);
    chk({7'h0, wm}, 8'h00);
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    {rst_n, wr, rd, diff, trig, lj, addr, wdata, code} = '0;
    ctl_v = 8'h90;
    err_total = 0;
    n_checks = 0;
    repeat (12) @(negedge clk);
    rst_n = 1;
    t_regs();
    t_single();
    t_diff();
    t_left();
    t_misc();
    conclude();
  end
  initial
  begin
    #60000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
endmodule // adc_window_detector_tb
`default_nettype wire
